// ### common/liu_pkg.sv
// constants, field layouts and carriers shared by the local interrupt unit
// assumes a single 250 MHz clock and a synchronous active-high reset
package liu_pkg;

   // sizes
   localparam int NUM_VECTORS = 256;
   localparam int VEC_W = 8;
   localparam int DATA_W = 64;
   localparam int IDX_W = 4;
   localparam int NUM_PINS = 2;
   localparam int NUM_INTERNAL = 3;
   localparam int PEND_WORDS = 4;
   localparam int CLASS_W = 4;

   // control register indices
   localparam logic [IDX_W-1:0] IDX_NODE_ID = 4'h0;
   localparam logic [IDX_W-1:0] IDX_HIGHEST = 4'h1;
   localparam logic [IDX_W-1:0] IDX_THRESHOLD = 4'h2;
   localparam logic [IDX_W-1:0] IDX_SERVICE_DONE = 4'h3;
   localparam logic [IDX_W-1:0] IDX_PENDING0 = 4'h4;
   localparam logic [IDX_W-1:0] IDX_PENDING1 = 4'h5;
   localparam logic [IDX_W-1:0] IDX_PENDING2 = 4'h6;
   localparam logic [IDX_W-1:0] IDX_PENDING3 = 4'h7;
   localparam logic [IDX_W-1:0] IDX_TIMER_VEC = 4'h8;
   localparam logic [IDX_W-1:0] IDX_PERF_VEC = 4'h9;
   localparam logic [IDX_W-1:0] IDX_CERR_VEC = 4'hA;
   localparam logic [IDX_W-1:0] IDX_PIN_ROUTE0 = 4'hB;
   localparam logic [IDX_W-1:0] IDX_PIN_ROUTE1 = 4'hC;

   // local entry field positions
   localparam int VEC_LSB = 0;
   localparam int VEC_MSB = 7;
   localparam int DELIV_LSB = 8;
   localparam int DELIV_MSB = 10;
   localparam int POL_BIT = 13;
   localparam int TRIG_BIT = 15;
   localparam int MASK_BIT = 16;
   localparam int ENTRY_MSB = 16;

   // node identifier field positions
   localparam int XID_LSB = 16;
   localparam int XID_MSB = 23;
   localparam int ID_LSB = 24;
   localparam int ID_MSB = 31;
   localparam int NODE_MSB = 31;

   // threshold register class field
   localparam int CLASS_LSB = 4;
   localparam int CLASS_MSB = 7;
   localparam int THRESH_MSB = 7;

   // delivery kinds of a pin entry
   localparam logic [2:0] DELIV_FIXED = 3'h0;
   localparam logic [2:0] DELIV_MGMT = 3'h2;
   localparam logic [2:0] DELIV_NMI = 3'h4;
   localparam logic [2:0] DELIV_INIT = 3'h5;
   localparam logic [2:0] DELIV_LEGACY = 3'h7;

   // vectors reported by the highest vector register
   localparam logic [VEC_W-1:0] NMI_VECTOR = 8'h02;
   localparam logic [VEC_W-1:0] LEGACY_VECTOR = 8'h00;
   localparam logic [VEC_W-1:0] SPURIOUS_VECTOR = 8'h0F;
   localparam logic [VEC_W-1:0] MIN_MASKABLE = 8'h10;

   // reset values
   localparam logic [DATA_W-1:0] NODE_ID_RESET = 64'h0000_0000_0000_0000;
   localparam logic [DATA_W-1:0] THRESHOLD_RESET = 64'h0000_0000_0000_0000;
   localparam logic [DATA_W-1:0] ENTRY_RESET = 64'h0000_0000_0001_0000;

   // control register request from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [IDX_W-1:0] idx;
      logic [DATA_W-1:0] wdata;
   } cr_req_t;

   // interrupt message from the system bus
   typedef struct packed {
      logic valid;
      logic [VEC_W-1:0] id;
      logic [VEC_W-1:0] xid;
      logic [VEC_W-1:0] vector;
   } int_msg_t;

endpackage

// ### rtl/prio_encoder.sv
// highest-set-bit finder over a bit vector, purely combinational
// assumes the caller registers whatever it derives from the result
`timescale 1ns/1ns
module prio_encoder #(
   parameter int W = 256
) (
   input wire logic [W-1:0] bits,
   output logic found,
   output logic [$clog2(W)-1:0] index
);

   // a width that is not a power of two would leave index codes unused
   if (W < 2 || (W & (W - 1)) != 0) begin : g_bad_width
      $error("prio_encoder width must be a power of two");
   end

   // later hits overwrite earlier ones, so the top set bit wins
   always_comb begin
      found = 1'b0;
      index = '0;
      for (int i = 0; i < W; i++) begin
         if (bits[i]) begin
            found = 1'b1;
            index = i[$clog2(W)-1:0];
         end
      end
   end

endmodule

// ### rtl/local_interrupt_unit.sv
// local interrupt unit: pends bus messages, internal events and two pins
// assumes control-register requests and internal events are on clk; pins are async
`timescale 1ns/1ns
module local_interrupt_unit
   import liu_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire cr_req_t cr_req,
   output logic [DATA_W-1:0] cr_rdata,
   output logic cr_rvalid,
   input wire int_msg_t msg,
   input wire logic timer_event,
   input wire logic perf_event,
   input wire logic cerr_event,
   input wire logic local_pin_zero,
   input wire logic local_pin_one,
   output logic ext_int_req,
   output logic nmi_req,
   output logic init_req,
   output logic mgmt_req,
   output logic [3:0] mgmt_vector,
   output logic acknowledge_cycle
);

   // software-visible state
   logic [NODE_MSB:0] node_id_reg;
   logic [THRESH_MSB:0] priority_threshold_reg;
   logic [ENTRY_MSB:0] internal_entry_reg [NUM_INTERNAL];
   logic [ENTRY_MSB:0] pin_routing_reg [NUM_PINS];
   logic [NUM_VECTORS-1:0] pending_bits_reg;
   logic [NUM_VECTORS-1:0] in_service_reg;
   logic nmi_pending_reg;
   logic legacy_pending_reg;

   // pin conditioning state
   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_meta_reg;
   logic [NUM_PINS-1:0] pin_sync_reg;
   logic [NUM_PINS-1:0] pin_active;
   logic [NUM_PINS-1:0] pin_active_reg;
   logic [NUM_PINS-1:0] pin_assert;
   logic [NUM_PINS-1:0] pin_deassert;

   // arbitration results
   logic pend_found;
   logic [VEC_W-1:0] pend_top;
   logic serv_found;
   logic [VEC_W-1:0] serv_top;
   logic [VEC_W-1:0] report_vector;
   logic [NUM_VECTORS-1:0] set_bits;
   logic [NUM_VECTORS-1:0] clr_bits;
   logic [NUM_VECTORS-1:0] serv_set;
   logic [NUM_VECTORS-1:0] serv_clr;
   logic msg_accept;
   logic highest_read;
   logic done_write;
   logic [NUM_INTERNAL-1:0] internal_fire;
   logic deliver_ok;

   assign pin_raw = {local_pin_one, local_pin_zero};
   assign internal_fire = {cerr_event, perf_event, timer_event};

   // target match against our own node id and extended id
   assign msg_accept = msg.valid
      && msg.id == node_id_reg[ID_MSB:ID_LSB]
      && msg.xid == node_id_reg[XID_MSB:XID_LSB];

   assign highest_read = cr_req.rd && cr_req.idx == IDX_HIGHEST;
   assign done_write = cr_req.wr && cr_req.idx == IDX_SERVICE_DONE;

   // two-flop synchroniser per pin; only the second stage is looked at
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // polarity is folded in first, so detection sees the active sense;
   // flipping polarity while the pin is still can itself look like an edge
   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p++) begin : g_pin
         assign pin_active[p] = pin_sync_reg[p] ^ pin_routing_reg[p][POL_BIT];
         assign pin_assert[p] = pin_active[p] && !pin_active_reg[p]
            && !pin_routing_reg[p][MASK_BIT];
         assign pin_deassert[p] = !pin_active[p] && pin_active_reg[p]
            && !pin_routing_reg[p][MASK_BIT]
            && pin_routing_reg[p][TRIG_BIT];
      end
   endgenerate

   // previous active sense, tracked even while masked
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_active_reg <= '0;
      end else begin
         pin_active_reg <= pin_active;
      end
   end

   // top pending vector over messages, internal events and fixed-mode pins together
   prio_encoder #(
      .W(NUM_VECTORS)
   ) u_pend_enc (
      .bits(pending_bits_reg),
      .found(pend_found),
      .index(pend_top)
   );

   // top vector currently being serviced
   prio_encoder #(
      .W(NUM_VECTORS)
   ) u_serv_enc (
      .bits(in_service_reg),
      .found(serv_found),
      .index(serv_top)
   );

   // non-maskable first, then vectored, then the legacy controller
   always_comb begin
      if (nmi_pending_reg) begin
         report_vector = NMI_VECTOR;
      end else if (pend_found) begin
         report_vector = pend_top;
      end else if (legacy_pending_reg) begin
         report_vector = LEGACY_VECTOR;
      end else begin
         report_vector = SPURIOUS_VECTOR;
      end
   end

   // collect every source that pends a vector this cycle
   always_comb begin
      set_bits = '0;
      if (msg_accept) begin
         set_bits[msg.vector] = 1'b1;
      end
      for (int s = 0; s < NUM_INTERNAL; s++) begin
         // internal events: edge only, local only, just vector and mask
         if (internal_fire[s] && !internal_entry_reg[s][MASK_BIT]) begin
            set_bits[internal_entry_reg[s][VEC_MSB:VEC_LSB]] = 1'b1;
         end
      end
      for (int q = 0; q < NUM_PINS; q++) begin
         if (pin_assert[q] && pin_routing_reg[q][DELIV_MSB:DELIV_LSB] == DELIV_FIXED) begin
            set_bits[pin_routing_reg[q][VEC_MSB:VEC_LSB]] = 1'b1;
         end
      end
   end

   // withdrawals: level pins going inactive and the reported vector
   always_comb begin
      clr_bits = '0;
      for (int q = 0; q < NUM_PINS; q++) begin
         if (pin_deassert[q] && pin_routing_reg[q][DELIV_MSB:DELIV_LSB] == DELIV_FIXED) begin
            clr_bits[pin_routing_reg[q][VEC_MSB:VEC_LSB]] = 1'b1;
         end
      end
      if (highest_read && !nmi_pending_reg && pend_found) begin
         clr_bits[pend_top] = 1'b1;
      end
   end

   // pending set: a new arrival beats a same-cycle clear; the mask gates
   // new occurrences and level withdrawals, so bits already pended stay put
   always_ff @(posedge clk) begin
      if (reset) begin
         pending_bits_reg <= '0;
      end else begin
         pending_bits_reg <= (pending_bits_reg & ~clr_bits) | set_bits;
      end
   end

   // in-service tracking drives nesting; service-done retires the top one
   always_comb begin
      serv_set = '0;
      serv_clr = '0;
      if (highest_read && !nmi_pending_reg && pend_found) begin
         serv_set[pend_top] = 1'b1;
      end
      if (done_write && serv_found) begin
         serv_clr[serv_top] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         in_service_reg <= '0;
      end else begin
         in_service_reg <= (in_service_reg & ~serv_clr) | serv_set;
      end
   end

   // non-maskable and legacy flags; arrival wins over the read that clears
   always_ff @(posedge clk) begin
      if (reset) begin
         nmi_pending_reg <= 1'b0;
         legacy_pending_reg <= 1'b0;
      end else begin
         if (highest_read && nmi_pending_reg) begin
            nmi_pending_reg <= 1'b0;
         end
         if (highest_read && !nmi_pending_reg && !pend_found && legacy_pending_reg) begin
            legacy_pending_reg <= 1'b0;
         end
         for (int q = 0; q < NUM_PINS; q++) begin
            if (pin_assert[q] && pin_routing_reg[q][DELIV_MSB:DELIV_LSB] == DELIV_NMI) begin
               nmi_pending_reg <= 1'b1;
            end
            if (pin_assert[q] && pin_routing_reg[q][DELIV_MSB:DELIV_LSB] == DELIV_LEGACY) begin
               legacy_pending_reg <= 1'b1;
            end
         end
      end
   end

   // strobes to the core for the dedicated lines; reserved codes fall through
   always_ff @(posedge clk) begin
      if (reset) begin
         nmi_req <= 1'b0;
         init_req <= 1'b0;
         mgmt_req <= 1'b0;
         mgmt_vector <= 4'h0;
      end else begin
         nmi_req <= 1'b0;
         init_req <= 1'b0;
         mgmt_req <= 1'b0;
         for (int q = 0; q < NUM_PINS; q++) begin
            if (pin_assert[q]) begin
               unique case (pin_routing_reg[q][DELIV_MSB:DELIV_LSB])
                  DELIV_NMI: begin
                     nmi_req <= 1'b1;
                  end
                  DELIV_INIT: begin
                     init_req <= 1'b1;
                  end
                  DELIV_MGMT: begin
                     mgmt_req <= 1'b1;
                     mgmt_vector <= pin_routing_reg[q][3:0];
                  end
                  default: begin
                     // fixed and legacy pend elsewhere; 001/011/110 do nothing
                  end
               endcase
            end
         end
      end
   end

   // delivery gate: pending class must beat both threshold and in-service
   assign deliver_ok = pend_found
      && pend_top >= MIN_MASKABLE
      && pend_top[VEC_W-1:CLASS_LSB] > priority_threshold_reg[CLASS_MSB:CLASS_LSB]
      && (!serv_found || pend_top[VEC_W-1:CLASS_LSB] > serv_top[VEC_W-1:CLASS_LSB]);

   // vectored or legacy request level toward the core
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_int_req <= 1'b0;
      end else begin
         ext_int_req <= deliver_ok || legacy_pending_reg;
      end
   end

   // legacy vector fetch: the read itself becomes the acknowledge cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         acknowledge_cycle <= 1'b0;
      end else begin
         acknowledge_cycle <= highest_read && !nmi_pending_reg
            && !pend_found && legacy_pending_reg;
      end
   end

   // whole-word writes; unused upper bits are simply dropped
   always_ff @(posedge clk) begin
      if (reset) begin
         node_id_reg <= NODE_ID_RESET[NODE_MSB:0];
         priority_threshold_reg <= THRESHOLD_RESET[THRESH_MSB:0];
         for (int s = 0; s < NUM_INTERNAL; s++) begin
            internal_entry_reg[s] <= ENTRY_RESET[ENTRY_MSB:0];
         end
         for (int q = 0; q < NUM_PINS; q++) begin
            pin_routing_reg[q] <= ENTRY_RESET[ENTRY_MSB:0];
         end
      end else if (cr_req.wr) begin
         // the new value steers logic from the next cycle on
         unique case (cr_req.idx)
            IDX_NODE_ID: begin
               node_id_reg <= cr_req.wdata[NODE_MSB:0];
            end
            IDX_THRESHOLD: begin
               priority_threshold_reg <= cr_req.wdata[THRESH_MSB:0];
            end
            IDX_TIMER_VEC: begin
               internal_entry_reg[0] <= cr_req.wdata[ENTRY_MSB:0];
            end
            IDX_PERF_VEC: begin
               internal_entry_reg[1] <= cr_req.wdata[ENTRY_MSB:0];
            end
            IDX_CERR_VEC: begin
               internal_entry_reg[2] <= cr_req.wdata[ENTRY_MSB:0];
            end
            IDX_PIN_ROUTE0: begin
               pin_routing_reg[0] <= cr_req.wdata[ENTRY_MSB:0];
            end
            IDX_PIN_ROUTE1: begin
               pin_routing_reg[1] <= cr_req.wdata[ENTRY_MSB:0];
            end
            default: begin
               // read-only and unmapped indices swallow writes
            end
         endcase
      end
   end

   // read data registered one cycle after the request; ignored bits read 0
   always_ff @(posedge clk) begin
      if (reset) begin
         cr_rdata <= '0;
         cr_rvalid <= 1'b0;
      end else begin
         cr_rvalid <= cr_req.rd;
         cr_rdata <= '0;
         if (cr_req.rd) begin
            unique case (cr_req.idx)
               IDX_NODE_ID: cr_rdata[NODE_MSB:0] <= node_id_reg;
               IDX_HIGHEST: cr_rdata[VEC_W-1:0] <= report_vector;
               IDX_THRESHOLD: cr_rdata[THRESH_MSB:0] <= priority_threshold_reg;
               IDX_PENDING0: cr_rdata <= pending_bits_reg[63:0];
               IDX_PENDING1: cr_rdata <= pending_bits_reg[127:64];
               IDX_PENDING2: cr_rdata <= pending_bits_reg[191:128];
               IDX_PENDING3: cr_rdata <= pending_bits_reg[255:192];
               IDX_TIMER_VEC: cr_rdata[ENTRY_MSB:0] <= internal_entry_reg[0];
               IDX_PERF_VEC: cr_rdata[ENTRY_MSB:0] <= internal_entry_reg[1];
               IDX_CERR_VEC: cr_rdata[ENTRY_MSB:0] <= internal_entry_reg[2];
               IDX_PIN_ROUTE0: cr_rdata[ENTRY_MSB:0] <= pin_routing_reg[0];
               IDX_PIN_ROUTE1: cr_rdata[ENTRY_MSB:0] <= pin_routing_reg[1];
               default: cr_rdata <= '0;
            endcase
         end
      end
   end

endmodule

// ### verif/liu_monitor.sv
// port-level assertions for the local interrupt unit
// bound into local_interrupt_unit below; one clock, sync reset
`timescale 1ns/1ns
module liu_monitor
   import liu_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire cr_req_t cr_req,
   input wire logic [DATA_W-1:0] cr_rdata,
   input wire logic cr_rvalid,
   input wire logic nmi_req,
   input wire logic init_req,
   input wire logic mgmt_req,
   input wire logic [3:0] mgmt_vector,
   input wire logic acknowledge_cycle
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // reads whose answers have a fixed shape
   sequence s_rd_top; cr_req.rd && cr_req.idx == IDX_HIGHEST; endsequence
   sequence s_rd_done; cr_req.rd && cr_req.idx == IDX_SERVICE_DONE; endsequence
   property p_answer; cr_req.rd |=> cr_rvalid; endproperty
   a_answer: assert property (p_answer) else $error("read unanswered");
   property p_idle; !cr_rvalid |-> cr_rdata == '0; endproperty
   a_idle: assert property (p_idle) else $error("stray read data");
   // a vector answer never carries more than 8 bits
   property p_top; s_rd_top ##1 cr_rvalid |-> cr_rdata[DATA_W-1:VEC_W] == '0; endproperty
   a_top: assert property (p_top) else $error("vector too wide");
   property p_done; s_rd_done |=> cr_rvalid && cr_rdata == '0; endproperty
   a_done: assert property (p_done) else $error("service done reads back");
   property p_nmi; nmi_req |=> !nmi_req; endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not a pulse");
   property p_init; init_req |=> !init_req; endproperty
   a_init: assert property (p_init) else $error("init not a pulse");
   // the platform vector moves only with its strobe
   property p_mgmt; !mgmt_req |-> $stable(mgmt_vector); endproperty
   a_mgmt: assert property (p_mgmt) else $error("platform vector moved");
   property p_ack;
      acknowledge_cycle |-> $past(cr_req.rd) && $past(cr_req.idx) == IDX_HIGHEST;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge without read");
endmodule

bind local_interrupt_unit liu_monitor u_monitor (.clk(clk), .reset(reset), .cr_req(cr_req),
   .cr_rdata(cr_rdata), .cr_rvalid(cr_rvalid), .nmi_req(nmi_req), .init_req(init_req),
   .mgmt_req(mgmt_req), .mgmt_vector(mgmt_vector), .acknowledge_cycle(acknowledge_cycle));

// ### verif/core_model.sv
// behavioural core: counts the strobes the unit raises toward it
// assumes strobes are one-cycle registered pulses on clk
`timescale 1ns/1ns
module core_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic nmi_req,
   input wire logic init_req,
   input wire logic mgmt_req,
   input wire logic [3:0] mgmt_vector,
   input wire logic acknowledge_cycle,
   output int cnt[4],
   output logic [3:0] mgmt_seen
);
   // order: non-maskable, init, platform, legacy acknowledge
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt <= '{0, 0, 0, 0};
      end else begin
         cnt[0] <= cnt[0] + int'(nmi_req);
         cnt[1] <= cnt[1] + int'(init_req);
         cnt[2] <= cnt[2] + int'(mgmt_req);
         cnt[3] <= cnt[3] + int'(acknowledge_cycle);
      end
   end
   // vector latched only with its strobe, as a real core would
   always_ff @(posedge clk) begin
      if (reset) begin
         mgmt_seen <= 4'h0;
      end else if (mgmt_req) begin
         mgmt_seen <= mgmt_vector;
      end
   end
endmodule

// ### verif/local_interrupt_unit_bench.sv
// self-checking bench with a reference model of pending state
// assumes liu_pkg, the unit, liu_monitor and core_model compile first
`timescale 1ns/1ns
module local_interrupt_unit_bench;
   import liu_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   cr_req_t cr_req = '0;
   int_msg_t msg = '0;
   logic [2:0] ev = 3'h0;
   logic pin0 = 1'b1;
   logic pin1 = 1'b0;
   logic [DATA_W-1:0] cr_rdata;
   logic cr_rvalid;
   logic ext_int_req;
   logic nmi_req;
   logic init_req;
   logic mgmt_req;
   logic [3:0] mgmt_vector;
   logic acknowledge_cycle;
   int cnt[4];
   logic [3:0] mgmt_seen;
   // model: pending bits, non-maskable and legacy flags, strobe counts
   logic [NUM_VECTORS-1:0] m_pend = '0;
   logic m_nmi = 1'b0;
   logic m_leg = 1'b0;
   int e_cnt[4] = '{0, 0, 0, 0};
   int seed = 22;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [7:0] nid;
   logic [7:0] neid;
   logic [7:0] v;
   logic [7:0] iv[NUM_INTERNAL];
   logic [63:0] ent;

   local_interrupt_unit u_dut (.clk(clk), .reset(reset), .cr_req(cr_req),
      .cr_rdata(cr_rdata), .cr_rvalid(cr_rvalid), .msg(msg), .timer_event(ev[0]),
      .perf_event(ev[1]), .cerr_event(ev[2]), .local_pin_zero(pin0), .local_pin_one(pin1),
      .ext_int_req(ext_int_req), .nmi_req(nmi_req), .init_req(init_req), .mgmt_req(mgmt_req),
      .mgmt_vector(mgmt_vector), .acknowledge_cycle(acknowledge_cycle));
   core_model u_core (.clk(clk), .reset(reset), .nmi_req(nmi_req), .init_req(init_req),
      .mgmt_req(mgmt_req), .mgmt_vector(mgmt_vector), .acknowledge_cycle(acknowledge_cycle),
      .cnt(cnt), .mgmt_seen(mgmt_seen));

   always #2 clk = ~clk;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   function automatic logic [7:0] rand_vec();
      return 8'(16 + $unsigned($random(seed)) % 240);
   endfunction
   // one-cycle write strobe; a cycle passes before the next request
   task automatic wr(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
      @(negedge clk);
      cr_req.wr = 1'b1;
      cr_req.idx = i;
      cr_req.wdata = d;
      @(negedge clk);
      cr_req.wr = 1'b0;
   endtask
   // read pulse, then a bounded wait for the registered answer
   task automatic rd(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] e);
      int k;
      @(negedge clk);
      cr_req.rd = 1'b1;
      cr_req.idx = i;
      @(negedge clk);
      cr_req.rd = 1'b0;
      for (k = 0; k < 4 && cr_rvalid !== 1'b1; k++) @(negedge clk);
      if (k == 4) begin
         n_mismatch++;
         $display("wrong value at %0t: read not answered", $time);
         tally_and_finish();
      end else begin
         check(cr_rdata, e);
      end
   endtask
   task automatic chk_pend();
      for (int w = 0; w < PEND_WORDS; w++) rd(4'(IDX_PENDING0 + w), m_pend[w*64 +: 64]);
   endtask
   // model of the highest-vector read: non-maskable, vectored, legacy, spurious
   task automatic serve();
      logic [7:0] e;
      e = SPURIOUS_VECTOR;
      if (m_leg) e = LEGACY_VECTOR;
      for (int k = 0; k < NUM_VECTORS; k++) if (m_pend[k]) e = 8'(k);
      if (m_nmi) e = NMI_VECTOR;
      if (m_nmi) m_nmi = 1'b0;
      else if (m_pend != '0) m_pend[e] = 1'b0;
      else m_leg = 1'b0;
      rd(IDX_HIGHEST, {56'h0, e});
      wr(IDX_SERVICE_DONE, 64'h0);
   endtask
   task automatic send(input logic [7:0] x);
      @(negedge clk);
      msg = '{1'b1, nid, neid, x};
      m_pend[x] = 1'b1;
      @(negedge clk);
      msg.valid = 1'b0;
   endtask
   // request line is registered from pending state, so let it settle
   task automatic ext_is(input logic e);
      wait_n(3);
      check({63'h0, ext_int_req}, {63'h0, e});
   endtask
   task automatic pin0_step(input logic lvl, input logic p);
      pin0 = lvl;
      wait_n(6);
      m_pend[8'h55] = p;
      chk_pend();
   endtask

   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      // reset values, write-only and unmapped places
      for (int i = 0; i < 16; i++) begin
         ent = (i >= 8 && i <= 12) ? ENTRY_RESET : 64'h0;
         if (i == 1) ent = {56'h0, SPURIOUS_VECTOR};
         rd(4'(i), ent);
      end
      nid = 8'($random(seed));
      neid = 8'($random(seed));
      wr(IDX_NODE_ID, {32'h0, nid, neid, 16'h0});
      rd(IDX_NODE_ID, {32'h0, nid, neid, 16'h0});
      wr(IDX_PENDING2, '1);
      wr(IDX_HIGHEST, '1);
      // back-to-back messages, every other one aimed at another node
      for (int n = 0; n < 8; n++) begin
         v = rand_vec();
         @(negedge clk);
         msg = '{1'b1, nid, neid, v};
         m_pend[v] = 1'b1;
         @(negedge clk);
         msg = '{1'b1, nid ^ 8'(n % 2), neid ^ 8'(1 - n % 2), rand_vec()};
      end
      @(negedge clk);
      msg.valid = 1'b0;
      wait_n(2);
      chk_pend();
      repeat (9) serve();
      chk_pend();
      // threshold class and in-service class both gate the request
      wr(IDX_THRESHOLD, 64'h50);
      rd(IDX_THRESHOLD, 64'h50);
      send(8'h5A);
      ext_is(1'b0);
      send(8'h6B);
      ext_is(1'b1);
      serve();
      ext_is(1'b0);
      rd(IDX_HIGHEST, {56'h0, 8'h5A});
      m_pend[8'h5A] = 1'b0;
      wr(IDX_THRESHOLD, 64'h0);
      ext_is(1'b0);
      // same class as the one in service waits for the service-done write
      send(8'h55);
      ext_is(1'b0);
      wr(IDX_SERVICE_DONE, 64'h0);
      ext_is(1'b1);
      serve();
      // internal sources: timer and corrected error open, perf masked
      for (int s = 0; s < NUM_INTERNAL; s++) begin
         iv[s] = rand_vec();
         ent = {47'h0, s == 1, 8'h0, iv[s]};
         wr(4'(IDX_TIMER_VEC + s), ent | 64'hF000_0000_0000_0000);
         rd(4'(IDX_TIMER_VEC + s), ent);
      end
      @(negedge clk);
      ev = 3'h7;
      @(negedge clk);
      ev = 3'h0;
      m_pend[iv[0]] = 1'b1;
      m_pend[iv[2]] = 1'b1;
      wait_n(2);
      chk_pend();
      repeat (3) serve();
      // pin zero: active low, level sensitive, then masked while asserted
      wr(IDX_PIN_ROUTE0, 64'hF000_0000_0000_A055);
      rd(IDX_PIN_ROUTE0, 64'hA055);
      pin0_step(1'b0, 1'b1);
      pin0_step(1'b1, 1'b0);
      pin0_step(1'b0, 1'b1);
      wr(IDX_PIN_ROUTE0, 64'h1_A055);
      pin0_step(1'b1, 1'b1);
      serve();
      // pin one, edge sensitive, through every delivery kind
      for (int c = 0; c < 8; c++) begin
         wr(IDX_PIN_ROUTE1, {53'h0, 3'(c), 8'hA3});
         pin1 = 1'b1;
         wait_n(6);
         if (c == 0) m_pend[8'hA3] = 1'b1;
         m_nmi = (c == 4);
         m_leg = (c == 7);
         e_cnt[0] += int'(c == 4);
         e_cnt[1] += int'(c == 5);
         e_cnt[2] += int'(c == 2);
         e_cnt[3] += int'(c == 7);
         check({63'h0, ext_int_req}, {63'h0, c == 0 || c == 7});
         serve();
         for (int j = 0; j < 4; j++) check(64'(cnt[j]), 64'(e_cnt[j]));
         pin1 = 1'b0;
         wait_n(6);
      end
      check({60'h0, mgmt_seen}, 64'h3);
      tally_and_finish();
   end
endmodule
